// ==== spi_master_slave_select_core.sv ====
/*
 * Serial peripheral port core: master/slave byte shifter with slave select
 * management, status flags and clearing sequences.
 * Assumes all inputs synchronous to clk, including the pin inputs in slave
 * mode; the external clock must be slower than half the cpu clock.
 */
`timescale 1ns/10ps
`include "spi_core_consts.svh"
module spi_master_slave_select_core
    import spi_core_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Software access
    input wire cpu_access_s cpu,
    input wire logic cpu_irq_mask,
    output logic [7:0] serial_control_reg,
    output logic [7:0] serial_control_status_reg,
    output logic [7:0] serial_data_reg,
    output logic irq,
    // Serial pins
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic ss_n_i,
    output pin_drive_s pins
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0] ctl_q, csr_q, rx_q, shift_q, half_q, cnt_q;
    logic [3:0] bits_q;
    logic sck_q, sck_in_q, busy_q, csr_seen_q, mode_fault_flag_seen_q, out_q;
    shift_state_e st_q;
    logic ss_int, is_master, enabled, clock_polarity, clock_phase, wr_ok, wr_coll;
    logic slave_sel, edge_lead, edge_trail, done_evt, m_tick, sin;

    // Divisor decode; codes 5, 6 and 7 all give the slowest rate
    function automatic logic [7:0] half_period(input logic [2:0] code);
        case (code)
            3'h0: half_period = `HALF_DIV2; // cpu/4
            3'h1: half_period = `HALF_DIV3;
            3'h2: half_period = `HALF_DIV4;
            3'h3: half_period = `HALF_DIV5;
            3'h4: half_period = `HALF_DIV6;
            default: half_period = `HALF_DIV7;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Select and configuration decode
    // ------------------------------------------------------------------------
    assign ss_int = csr_q[`CSR_SSM_BIT] ? csr_q[`CSR_SSI_BIT] : ss_n_i;
    assign is_master = ctl_q[`CTL_MASTER_BIT];
    assign enabled = ctl_q[`CTL_ENABLE_BIT];
    assign clock_polarity = ctl_q[`CTL_POL_BIT];
    assign clock_phase = ctl_q[`CTL_PHASE_BIT];
    assign slave_sel = enabled && !is_master && !ss_int;
    // Data writes pass only when idle, done not pending, and no phase-0 select
    assign wr_coll = cpu.data_wr && (busy_q || (slave_sel && !clock_phase));
    assign wr_ok = cpu.data_wr && !wr_coll
        && !(csr_q[`CSR_DONE_BIT] && !csr_seen_q);
    assign m_tick = busy_q && is_master && (cnt_q == half_q);
    // External clock edges; sck_in_q is a plain delay, pins are synchronous
    assign edge_lead = is_master ? (m_tick && st_q == ST_LEAD)
        : (slave_sel && (sck_i != sck_in_q) && (sck_i != clock_polarity));
    assign edge_trail = is_master ? (m_tick && st_q == ST_TRAIL)
        : (slave_sel && (sck_i != sck_in_q) && (sck_i == clock_polarity));
    assign sin = is_master ? miso_i : mosi_i;
    assign done_evt = edge_trail && bits_q == 4'h1 && busy_q;

    // ------------------------------------------------------------------------
    // Control register; fault drops master and enable
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= `CTL_RESET;
        end else if (is_master && enabled && !ss_int) begin
            ctl_q[`CTL_MASTER_BIT] <= 1'b0;
            ctl_q[`CTL_ENABLE_BIT] <= 1'b0;
        end else if (cpu.ctl_wr) begin
            ctl_q <= cpu.wdata;
            // Master/enable accepted only with select high, fault not held
            if (!ss_int || (csr_q[`CSR_MODE_FAULT_FLAG_BIT] && !mode_fault_flag_seen_q)) begin
                ctl_q[`CTL_MASTER_BIT] <= 1'b0;
                ctl_q[`CTL_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Status flags; a hardware set wins over a software clear
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            csr_q <= `CSR_RESET;
            csr_seen_q <= 1'b0;
            mode_fault_flag_seen_q <= 1'b0;
        end else begin
            if (cpu.csr_wr) begin
                csr_q[`CSR_SSM_BIT] <= cpu.wdata[`CSR_SSM_BIT];
                csr_q[`CSR_SSI_BIT] <= cpu.wdata[`CSR_SSI_BIT];
            end
            if (cpu.csr_rd || cpu.csr_wr) begin
                csr_seen_q <= csr_q[`CSR_DONE_BIT] || csr_q[`CSR_WRITE_COLLISION_FLAG_BIT];
            end
            if (cpu.csr_rd) begin
                mode_fault_flag_seen_q <= csr_q[`CSR_MODE_FAULT_FLAG_BIT];
                csr_q[`CSR_OVR_BIT] <= 1'b0;
            end
            // Status then data access clears done and collision
            if (csr_seen_q && (cpu.data_rd || cpu.data_wr)) begin
                csr_q[`CSR_DONE_BIT] <= 1'b0;
                csr_q[`CSR_WRITE_COLLISION_FLAG_BIT] <= 1'b0;
                csr_seen_q <= 1'b0;
            end
            if (mode_fault_flag_seen_q && cpu.ctl_wr) begin
                csr_q[`CSR_MODE_FAULT_FLAG_BIT] <= 1'b0;
                mode_fault_flag_seen_q <= 1'b0;
            end
            if (done_evt) begin
                csr_q[`CSR_DONE_BIT] <= 1'b1;
                if (csr_q[`CSR_DONE_BIT]) begin
                    csr_q[`CSR_OVR_BIT] <= 1'b1;
                end
            end
            if (wr_coll) begin
                csr_q[`CSR_WRITE_COLLISION_FLAG_BIT] <= 1'b1; // no interrupt
            end
            if (is_master && enabled && !ss_int) begin
                csr_q[`CSR_MODE_FAULT_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Shift engine: byte shifted MSB first, both directions at once
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= 8'h00;
            rx_q <= 8'h00;
            bits_q <= 4'h0;
            busy_q <= 1'b0;
            out_q <= 1'b0;
            st_q <= ST_IDLE;
        end else if (!enabled) begin
            busy_q <= 1'b0;
            st_q <= ST_IDLE;
        end else begin
            if (wr_ok) begin
                shift_q <= cpu.wdata;
                out_q <= cpu.wdata[7];
                bits_q <= `BITS_PER_BYTE;
                busy_q <= is_master; // Slave waits for the master's clock
                st_q <= is_master ? ST_LEAD : ST_IDLE;
            end
            // Slave arms on its first clock edge even without a new byte
            if (!is_master && slave_sel && !busy_q && (edge_lead || edge_trail)) begin
                busy_q <= 1'b1;
                bits_q <= `BITS_PER_BYTE;
            end
            // Sample on the first edge for phase 0, second for phase 1
            if (edge_lead) begin
                if (!clock_phase) begin
                    shift_q <= {shift_q[6:0], sin};
                end else begin
                    out_q <= shift_q[7];
                end
                if (is_master) begin
                    st_q <= ST_TRAIL;
                end
            end
            if (edge_trail) begin
                if (clock_phase) begin
                    shift_q <= {shift_q[6:0], sin};
                end else begin
                    // The lead edge already shifted, so the next bit sits at the top
                    out_q <= shift_q[7];
                end
                bits_q <= bits_q - 4'h1;
                if (is_master) begin
                    st_q <= (bits_q == 4'h1) ? ST_IDLE : ST_LEAD;
                end
                if (bits_q == 4'h1) begin
                    busy_q <= 1'b0;
                    rx_q <= clock_phase ? {shift_q[6:0], sin} : shift_q;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Master clock generator; idles at the polarity level
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h01;
            half_q <= `HALF_DIV2;
            sck_q <= 1'b0;
            sck_in_q <= 1'b0;
        end else begin
            sck_in_q <= sck_i;
            half_q <= half_period(ctl_q[`CTL_RATE_LSB +: 3]);
            if (!busy_q || !is_master) begin
                cnt_q <= 8'h01;
                sck_q <= clock_polarity;
            end else if (m_tick) begin
                cnt_q <= 8'h01;
                sck_q <= ~sck_q;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs; pins released unless enabled in the matching role, miso also needing select low
    // ------------------------------------------------------------------------
    assign pins.sck_o = sck_q;
    assign pins.sck_oe = enabled && is_master;
    assign pins.mosi_o = out_q;
    assign pins.mosi_oe = enabled && is_master;
    assign pins.miso_o = out_q;
    assign pins.miso_oe = slave_sel;
    assign serial_control_reg = ctl_q;
    assign serial_control_status_reg = csr_q;
    assign serial_data_reg = rx_q;
    // Collision sets no interrupt; fault and done do
    assign irq = ctl_q[`CTL_IRQEN_BIT] && !cpu_irq_mask
        && (csr_q[`CSR_DONE_BIT] || csr_q[`CSR_MODE_FAULT_FLAG_BIT]);
endmodule

// ==== spi_core_consts.svh ====
/*
 * Constants for the serial port core: field positions, reset values, divisors.
 * Assumes inclusion by bare name from the package and the core.
 */
`ifndef SPI_CORE_CONSTS_SVH
`define SPI_CORE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTL_RATE_LSB 0
`define CTL_PHASE_BIT 3
`define CTL_POL_BIT 4
`define CTL_MASTER_BIT 5
`define CTL_ENABLE_BIT 6
`define CTL_IRQEN_BIT 7
`define CTL_RESET 8'h00
// ----------------------------------------------------------------------------
// Control/status register fields
// ----------------------------------------------------------------------------
`define CSR_SSI_BIT 0
`define CSR_SSM_BIT 1
`define CSR_MODE_FAULT_FLAG_BIT 4
`define CSR_OVR_BIT 5
`define CSR_WRITE_COLLISION_FLAG_BIT 6
`define CSR_DONE_BIT 7
`define CSR_RESET 8'h00
// ----------------------------------------------------------------------------
// Half-periods of the master clock in cpu cycles, indexed by the rate field
// ----------------------------------------------------------------------------
`define HALF_DIV2 8'h02
`define HALF_DIV3 8'h04
`define HALF_DIV4 8'h08
`define HALF_DIV5 8'h10
`define HALF_DIV6 8'h20
`define HALF_DIV7 8'h40
`define BITS_PER_BYTE 4'h8

`endif

// ==== spi_core_pkg.sv ====
/*
 * Types shared by the serial port core.
 * Assumes the constants header is on the include path.
 */
package spi_core_pkg;
    `include "spi_core_consts.svh"

    // Software access strobes, one cycle each
    typedef struct packed {
        logic ctl_wr;
        logic csr_wr;
        logic csr_rd;
        logic data_wr;
        logic data_rd;
        logic [7:0] wdata;
    } cpu_access_s;

    // Serial pins seen from the core
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } pin_drive_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LEAD = 3'b010,
        ST_TRAIL = 3'b100
    } shift_state_e;
endpackage

// ==== spi_core_asserts.sv ====
/* Checker for the serial port core, bound to the core's ports.
   Assumes one clock domain with a synchronous, active-high reset. */
`timescale 1ns/10ps
module spi_core_asserts
    import spi_core_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire cpu_access_s cpu,
    input wire logic cpu_irq_mask,
    input wire logic [7:0] serial_control_reg,
    input wire logic [7:0] serial_control_status_reg,
    input wire logic irq,
    input wire logic ss_n_i,
    input wire pin_drive_s pins
);
    // --------
    // Helpers
    // --------
    wire logic [7:0] ctl = serial_control_reg;
    wire logic [7:0] sts = serial_control_status_reg;
    wire logic sel = sts[1] ? sts[0] : ss_n_i;
    logic acc_q;
    // Status access seen while done is up; a data read alone must not clear
    always_ff @(posedge clk) begin
        if (rst || !sts[7]) acc_q <= 1'h0;
        else if (cpu.csr_rd || cpu.csr_wr) acc_q <= 1'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // --------
    // Properties
    // --------
    property p_rst_val; disable iff (1'h0) rst |=> ctl == 8'h00 && sts == 8'h00; endproperty
    a_rst_val: assert property (p_rst_val) else $error("registers not zero after reset");
    property p_irq_cause; irq |-> ctl[7] && !cpu_irq_mask; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq while off or masked");
    property p_irq_done; ctl[7] && !cpu_irq_mask && sts[7] |-> irq; endproperty
    a_irq_done: assert property (p_irq_done) else $error("done gave no irq");
    property p_write_collision_flag_quiet; sts[7:4] == 4'h4 |-> !irq; endproperty
    a_write_collision_flag_quiet: assert property (p_write_collision_flag_quiet) else $error("collision raised irq");
    property p_fault; ctl[6:5] == 2'h3 && !sel |=> ##[0:2] sts[4] && ctl[6:5] == 2'h0; endproperty
    a_fault: assert property (p_fault) else $error("low select kept master");
    property p_ssm; ctl[5] && sts[1:0] == 2'h3 && !cpu.ctl_wr && !cpu.csr_wr |=> ctl[5]; endproperty
    a_ssm: assert property (p_ssm) else $error("pin overrode soft select");
    property p_block; sts[7] && !acc_q && cpu.data_wr |=> sts[7] ##2 $stable(pins.sck_o); endproperty
    a_block: assert property (p_block) else $error("data write not blocked");
    property p_noclr; sts[7] && !acc_q && cpu.data_rd && !cpu.csr_rd |=> sts[7]; endproperty
    a_noclr: assert property (p_noclr) else $error("done cleared early");
    property p_idle; $rose(sts[7]) && ctl[5] |-> pins.sck_o == ctl[4]; endproperty
    a_idle: assert property (p_idle) else $error("clock not idle at done");
    property p_rate; ctl[5] && $changed(pins.sck_o) |=> $stable(pins.sck_o); endproperty
    a_rate: assert property (p_rate) else $error("clock above quarter rate");
    c_done: cover property ($rose(sts[7]));
    c_write_collision_flag: cover property ($rose(sts[6]));
    c_fault: cover property ($rose(sts[4]));
endmodule
bind spi_master_slave_select_core spi_core_asserts u_chk (.clk(clk), .rst(rst), .cpu(cpu),
    .cpu_irq_mask(cpu_irq_mask), .serial_control_reg(serial_control_reg), .irq(irq),
    .serial_control_status_reg(serial_control_status_reg), .ss_n_i(ss_n_i), .pins(pins));

// ==== spi_slave_model.sv ====
/* Behavioural serial slave that answers the core in master mode.
   Assumes the bench drives select, mode and the byte to return. */
`timescale 1ns/10ps
module spi_slave_model (
    // Serial lines
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso,
    // Setup
    input wire logic clock_polarity,
    input wire logic clock_phase,
    input wire logic [7:0] tx,
    output logic [7:0] rx
);
    int sh = 0;
    initial rx = 8'h00;
    initial miso = 1'h0;
    // Sample on the edge the mode picks, shift on the other; slave only
    always @(sck) begin
        if (!sel_n && (sck ^ clock_polarity ^ clock_phase)) rx = {rx[6:0], mosi};
        else if (!sel_n) sh = sh + 1;
    end
    always @(posedge sel_n) sh = 0;
    // Phase one waits for the first edge; released line shows the inverse
    always @(sel_n or sh or tx) begin
        if (!sel_n && sh - clock_phase < 8) miso = tx[7 - (sh > clock_phase ? sh - clock_phase : 0)];
        else miso = ~miso;
    end
endmodule

// ==== spi_master_slave_select_core_tb.sv ====
/* Testbench: the core as master against a slave model, all modes and rates,
   then as a slave clocked by the bench.
   Assumes the package, core, checker and slave model compile first. */
`timescale 1ns/10ps
module spi_master_slave_select_core_tb;
    import spi_core_pkg::*;
    // --------
    // Signals
    // --------
    localparam int CW = 0, SW = 1, SR = 2, DW = 3, DR = 4;
    localparam logic [7:0] MB = 8'hC5;
    logic clk = 1'h0, rst = 1'h1, mask = 1'h0, ss_n = 1'h1, sel_n = 1'h1, pol = 1'h0, pha = 1'h0;
    logic irq, miso_m, xs = 1'h0, xm = 1'h1;
    logic [7:0] tx = 8'h00, ctl, csr, dat, rx, sb = 8'h00;
    cpu_access_s cpu = '0;
    pin_drive_s pins;
    int error_cnt = 0, n_compared = 0, cyc = 0, n;
    // Board pulls: clock to polarity, mosi up, miso from the slave model; xs and xm act as outside master
    wire logic sck_w = pins.sck_oe ? pins.sck_o : (xs ^ pol);
    wire logic mosi_w = pins.mosi_oe ? pins.mosi_o : xm;
    wire logic miso_w = pins.miso_oe ? pins.miso_o : miso_m;
    spi_master_slave_select_core u_dut (.clk(clk), .rst(rst), .cpu(cpu), .cpu_irq_mask(mask),
        .serial_control_reg(ctl), .serial_control_status_reg(csr), .serial_data_reg(dat),
        .irq(irq), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(ss_n), .pins(pins));
    spi_slave_model u_sl (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n), .miso(miso_m),
        .clock_polarity(pol), .clock_phase(pha), .tx(tx), .rx(rx));
    // --------
    // Clock, ceiling and tasks
    // --------
    initial forever #4 clk = ~clk;
    // Longest run is a few thousand cycles, so this only trips on a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    // One-cycle strobe of the chosen access, launched at the falling edge
    task automatic acc(input int k, input logic [7:0] d);
        @(negedge clk) cpu = {5'h10 >> k, d};
        @(negedge clk) cpu = '0;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Bounded wait for done, cycles counted in n; slowest byte takes 1024 cycles
    task automatic wt;
        for (n = 0; csr[7] !== 1'h1 && n < 4000; n++) @(negedge clk);
        chk("wait", n < 4000, 1'h1);
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // --------
    // Tests
    // --------
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'h0;
        chk("ctl", ctl, 8'h00);
        chk("sck_oe", pins.sck_oe, 1'h0);
        ss_n = 1'h0;
        // Every mode and each of the six rates; pin held low throughout
        for (int m = 0; m < 6; m++) begin
            {pha, pol} = m[1:0];
            tx = 8'h96 ^ m[7:0];
            sel_n = 1'h1;
            acc(CW, {3'h0, pol, pha, m[2:0]});
            acc(SW, 8'h03);
            acc(CW, {3'h3, pol, pha, m[2:0]});
            chk("master", ctl[6:5], 2'h3);
            sel_n = 1'h0; // Slave selected for this byte only
            acc(DW, 8'h5C + m[7:0]);
            wt();
            chk("rx", rx, 8'h5C + m[7:0]);
            chk("dat", dat, tx);
            chk("time", n >= (32 << m) - 1 && n <= (32 << m) + 3, 1'h1);
            chk("sck", sck_w, pol);
            acc(DW, 8'hFF);
            repeat (40) @(negedge clk);
            acc(DR, 8'h00);
            chk("rx", rx, 8'h5C + m[7:0]);
            chk("sts", csr & 8'hF0, 8'h80);
            acc(SR, 8'h00);
            acc(DR, 8'h00);
            chk("done", csr[7], 1'h0);
        end
        // Second write in mid-transfer is dropped
        sel_n = 1'h1;
        @(negedge clk) sel_n = 1'h0;
        acc(DW, 8'h5A);
        acc(DW, 8'h99);
        chk("write_collision_flag", csr[6], 1'h1);
        wt();
        chk("rx", rx, 8'h5A);
        chk("irq", irq, 1'h0);
        acc(CW, 8'hF5);
        chk("irq", irq, 1'h1);
        mask = 1'h1;
        @(negedge clk) chk("irq", irq, 1'h0);
        mask = 1'h0;
        // Pin select while master trips the fault
        acc(SW, 8'h00);
        repeat (4) @(negedge clk);
        chk("fault", csr[4], 1'h1);
        chk("ms_en", ctl[6:5], 2'h0);
        ss_n = 1'h1;
        acc(SR, 8'h00);
        acc(CW, 8'h75);
        chk("fault", csr[4], 1'h0);
        // Core as phase-one slave, select held low by software, bench clocks it
        sel_n = 1'h1;
        {pha, pol} = 2'h2;
        acc(CW, 8'h08);
        acc(SW, 8'h03);
        acc(CW, 8'h48);
        acc(SW, 8'h02);
        acc(DW, 8'hA7);
        // Half periods of two cycles keep the clock below half the cpu rate
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk) {xs, xm} = {1'h1, MB[i]};
            repeat (2) @(negedge clk);
            sb = {sb[6:0], pins.miso_o};
            xs = 1'h0;
            @(negedge clk);
        end
        chk("slave_rx", dat, MB);
        chk("slave_tx", sb, 8'hA7);
        chk("miso_oe", pins.miso_oe, 1'h1);
        chk("done", csr[7], 1'h1);
        // Phase-zero slave still selected: loading the shifter collides
        acc(SW, 8'h03);
        acc(CW, 8'h40);
        acc(SW, 8'h02);
        acc(DW, 8'h3C);
        chk("write_collision_flag", csr[6], 1'h1);
        results();
    end
endmodule
